// >>> verilog/usbefs_map.svh
// register offsets, field positions, reset values and sizes of the endpoint status/fifo block
//
// What this block does
// - non-iso endpoints set stall-sent flag after a requested stall went out
// - iso endpoints show read-only crc error of latest reception, refreshed each packet
// - valid setup packet sets setup-received flag and raises endpoint interrupt
// - setting setup-received clears every other bit of the endpoint status
// - storing an OUT packet in bank 0 sets bank-0 received flag
// - while bank-0 flag set, further OUT packets get NAK, iso exempt
// - control endpoints accept an early setup even while bank-0 flag set
// - non-iso endpoints set transmit-complete after host acknowledges an IN packet
// - fifo data port moves one byte per access, write pushes, read pops
// - byte-count low register holds the low eight count bits of selected endpoint
// - byte count equals data bytes received after the data pid
// - count high register holds count bits 10..8 in bits 2..0, rest zero
`ifndef USBEFS_MAP_SVH
`define USBEFS_MAP_SVH

`define USBEFS_ADDR_EP_SELECT 8'hC7
`define USBEFS_ADDR_EP_STATUS 8'hCE
`define USBEFS_ADDR_FIFO_DATA 8'hCF
`define USBEFS_ADDR_COUNT_LOW 8'hE2
`define USBEFS_ADDR_COUNT_HIGH 8'hE3
`define USBEFS_ADDR_EP_INT 8'hF8

`define USBEFS_BIT_TX_COMPLETE 0
`define USBEFS_BIT_OUT_BANK0 1
`define USBEFS_BIT_SETUP 2
`define USBEFS_BIT_STALL_CRC 3

`define USBEFS_NUM_EP 7
`define USBEFS_CNT_W 11
`define USBEFS_FIFO_DEPTH 16
`define USBEFS_BYTE_W 8

`define USBEFS_RST_BYTE 8'h00
`define USBEFS_RST_EP 3'h0
`define USBEFS_RST_COUNT 11'h000

`endif

// >>> verilog/usbefs_pkg.sv
// types shared by the endpoint status/fifo block
`include "usbefs_map.svh"
package usbefs_pkg;
   typedef logic [`USBEFS_BYTE_W-1:0] usbefs_byte_t;
   typedef logic [2:0] usbefs_ep_t;
   typedef logic [`USBEFS_CNT_W-1:0] usbefs_cnt_t;
   typedef logic [`USBEFS_NUM_EP-1:0] usbefs_epmask_t;
   typedef enum logic {USBEFS_RX_IDLE, USBEFS_RX_DATA} usbefs_rx_e;
endpackage

// >>> verilog/usbefs_stream_if.sv
// byte stream with valid/ready between the block's own modules
`timescale 1ns/1ps
interface usbefs_stream_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// >>> verilog/usbefs_fifo.sv
// parameterised fifo with registered read data and valid/ready on both sides
`timescale 1ns/1ps
module usbefs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   usbefs_stream_if.snk wr,
   usbefs_stream_if.src rd
);
   import usbefs_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic out_valid;
   logic [WIDTH-1:0] out_data;
   logic do_wr;
   logic do_load;

   // the output register counts toward the depth, so full means DEPTH words held
   assign wr.ready = !((count == CW'(DEPTH)) || ((count == CW'(DEPTH - 1)) && out_valid));
   assign do_wr = wr.valid && wr.ready;
   // refill the output register when it is empty or being taken
   assign do_load = (count != '0) && (!out_valid || rd.ready);
   assign rd.valid = out_valid;
   assign rd.data = out_data;

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= wr.data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_load) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + CW'(do_wr) - CW'(do_load);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else if (do_load) begin
         out_valid <= 1'b1;
         out_data <= mem[rd_ptr];
      end else if (rd.ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule

// >>> verilog/usbefs_top.sv
// endpoint status flags, fifo data port and received byte count of the usb device
`timescale 1ns/1ps
`include "usbefs_map.svh"
module usbefs_top (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire usbefs_pkg::usbefs_byte_t SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire usbefs_pkg::usbefs_byte_t SFR_WDATA,
   output usbefs_pkg::usbefs_byte_t SFR_RDATA,
   input wire usbefs_pkg::usbefs_epmask_t EP_ISO,
   input wire usbefs_pkg::usbefs_epmask_t EP_CTRL,
   input wire usbefs_pkg::usbefs_epmask_t EP_INT_EN,
   output logic EP_INT,
   input wire usbefs_pkg::usbefs_ep_t LINK_EP,
   input wire logic LINK_SETUP,
   input wire logic LINK_RX_START,
   input wire logic LINK_RX_VALID,
   input wire usbefs_pkg::usbefs_byte_t LINK_RX_BYTE,
   output logic LINK_RX_READY,
   input wire logic LINK_RX_END,
   input wire logic LINK_CRC_ERR,
   output logic LINK_OUT_NAK,
   input wire logic LINK_STALL_SENT,
   input wire logic LINK_IN_ACK,
   output logic LINK_TX_VALID,
   output usbefs_pkg::usbefs_byte_t LINK_TX_BYTE,
   input wire logic LINK_TX_READY
);
   import usbefs_pkg::*;

   // ***************************************************
   // reset release
   // ***************************************************
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ***************************************************
   // decoding helpers
   // ***************************************************
   function automatic logic ep_hit(input usbefs_ep_t ep, input int idx);
      ep_hit = (ep == 3'(idx));
   endfunction

   function automatic logic addr_is(input usbefs_byte_t a, input usbefs_byte_t reg_addr);
      addr_is = (a == reg_addr);
   endfunction

   // ***************************************************
   // endpoint select register
   // ***************************************************
   usbefs_ep_t ep_sel;

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ep_sel <= `USBEFS_RST_EP;
      end else if (SFR_WR && addr_is(SFR_ADDR, `USBEFS_ADDR_EP_SELECT)) begin
         ep_sel <= SFR_WDATA[2:0];
      end
   end

   // ***************************************************
   // data fifos
   // ***************************************************
   usbefs_stream_if #(.WIDTH(`USBEFS_BYTE_W)) rx_in ();
   usbefs_stream_if #(.WIDTH(`USBEFS_BYTE_W)) rx_out ();
   usbefs_stream_if #(.WIDTH(`USBEFS_BYTE_W)) tx_in ();
   usbefs_stream_if #(.WIDTH(`USBEFS_BYTE_W)) tx_out ();

   usbefs_rx_e rx_state;
   logic rx_take;

   assign rx_in.data = LINK_RX_BYTE;
   assign rx_in.valid = LINK_RX_VALID && (rx_state == USBEFS_RX_DATA);
   assign LINK_RX_READY = rx_in.ready;
   assign rx_take = rx_in.valid && rx_in.ready;

   // firmware read of the data port pops one byte, write pushes one
   assign rx_out.ready = SFR_RD && addr_is(SFR_ADDR, `USBEFS_ADDR_FIFO_DATA);
   assign tx_in.valid = SFR_WR && addr_is(SFR_ADDR, `USBEFS_ADDR_FIFO_DATA);
   assign tx_in.data = SFR_WDATA;

   assign LINK_TX_VALID = tx_out.valid;
   assign LINK_TX_BYTE = tx_out.data;
   assign tx_out.ready = LINK_TX_READY;

   usbefs_fifo #(.WIDTH(`USBEFS_BYTE_W), .DEPTH(`USBEFS_FIFO_DEPTH)) u_rx_fifo (
      .clk(REF_CLK),
      .rst_n(rst_n),
      .wr(rx_in.snk),
      .rd(rx_out.src)
   );

   usbefs_fifo #(.WIDTH(`USBEFS_BYTE_W), .DEPTH(`USBEFS_FIFO_DEPTH)) u_tx_fifo (
      .clk(REF_CLK),
      .rst_n(rst_n),
      .wr(tx_in.snk),
      .rd(tx_out.src)
   );

   // ***************************************************
   // packet reception and byte count
   // ***************************************************
   usbefs_cnt_t rx_count;
   usbefs_cnt_t ep_count [`USBEFS_NUM_EP];

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         rx_state <= USBEFS_RX_IDLE;
      end else begin
         unique case (rx_state)
            USBEFS_RX_IDLE: begin
               if (LINK_RX_START && !LINK_OUT_NAK) begin
                  rx_state <= USBEFS_RX_DATA;
               end
            end
            USBEFS_RX_DATA: begin
               if (LINK_RX_END) begin
                  rx_state <= USBEFS_RX_IDLE;
               end
            end
         endcase
      end
   end

   // only bytes after the data pid reach this port, so each taken byte counts
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         rx_count <= `USBEFS_RST_COUNT;
      end else if (LINK_RX_START) begin
         rx_count <= `USBEFS_RST_COUNT;
      end else if (rx_take) begin
         rx_count <= rx_count + 1'b1;
      end
   end

   logic rx_done;
   logic rx_good;
   assign rx_done = LINK_RX_END && (rx_state == USBEFS_RX_DATA);
   assign rx_good = rx_done && !LINK_CRC_ERR;

   // ***************************************************
   // per-endpoint status flags
   // ***************************************************
   usbefs_epmask_t f_stall;
   usbefs_epmask_t f_setup;
   usbefs_epmask_t f_out;
   usbefs_epmask_t f_txc;
   usbefs_epmask_t ep_event;
   logic status_wr;

   assign status_wr = SFR_WR && addr_is(SFR_ADDR, `USBEFS_ADDR_EP_STATUS);

   // a non-iso bank already holding data refuses new OUT data, setups to control endpoints excepted
   assign LINK_OUT_NAK = f_out[LINK_EP] && !EP_ISO[LINK_EP]
                         && !(LINK_SETUP && EP_CTRL[LINK_EP]);

   genvar gi;
   generate
      for (gi = 0; gi < `USBEFS_NUM_EP; gi++) begin : g_ep
         logic here;
         logic sel_wr;
         logic set_setup;
         logic set_out;
         logic set_stall;
         logic set_txc;

         assign here = ep_hit(LINK_EP, gi);
         assign sel_wr = status_wr && ep_hit(ep_sel, gi);
         assign set_setup = rx_good && here && LINK_SETUP && EP_CTRL[gi];
         assign set_out = rx_good && here && !LINK_SETUP;
         assign set_stall = LINK_STALL_SENT && here && !EP_ISO[gi];
         assign set_txc = LINK_IN_ACK && here && !EP_ISO[gi];

         // firmware writes 0 to clear a flag; a hardware set in that cycle wins
         always_ff @(posedge REF_CLK or negedge rst_n) begin
            if (!rst_n) begin
               f_setup[gi] <= 1'b0;
            end else if (set_setup) begin
               f_setup[gi] <= 1'b1;
            end else if (sel_wr && !SFR_WDATA[`USBEFS_BIT_SETUP]) begin
               f_setup[gi] <= 1'b0;
            end
         end

         always_ff @(posedge REF_CLK or negedge rst_n) begin
            if (!rst_n) begin
               f_out[gi] <= 1'b0;
            end else if (set_setup) begin
               f_out[gi] <= 1'b0;
            end else if (set_out) begin
               f_out[gi] <= 1'b1;
            end else if (sel_wr && !SFR_WDATA[`USBEFS_BIT_OUT_BANK0]) begin
               f_out[gi] <= 1'b0;
            end
         end

         always_ff @(posedge REF_CLK or negedge rst_n) begin
            if (!rst_n) begin
               f_txc[gi] <= 1'b0;
            end else if (set_setup) begin
               f_txc[gi] <= 1'b0;
            end else if (set_txc) begin
               f_txc[gi] <= 1'b1;
            end else if (sel_wr && !SFR_WDATA[`USBEFS_BIT_TX_COMPLETE]) begin
               f_txc[gi] <= 1'b0;
            end
         end

         // iso endpoints: read-only crc flag, refreshed on every reception
         always_ff @(posedge REF_CLK or negedge rst_n) begin
            if (!rst_n) begin
               f_stall[gi] <= 1'b0;
            end else if (set_setup) begin
               f_stall[gi] <= 1'b0;
            end else if (EP_ISO[gi]) begin
               if (rx_done && here) begin
                  f_stall[gi] <= LINK_CRC_ERR;
               end
            end else if (set_stall) begin
               f_stall[gi] <= 1'b1;
            end else if (sel_wr && !SFR_WDATA[`USBEFS_BIT_STALL_CRC]) begin
               f_stall[gi] <= 1'b0;
            end
         end

         always_ff @(posedge REF_CLK or negedge rst_n) begin
            if (!rst_n) begin
               ep_count[gi] <= `USBEFS_RST_COUNT;
            end else if (rx_done && here) begin
               ep_count[gi] <= rx_count + usbefs_cnt_t'(rx_take);
            end
         end

         assign ep_event[gi] = f_stall[gi] || f_setup[gi] || f_out[gi] || f_txc[gi];
      end
   endgenerate

   // ***************************************************
   // endpoint interrupt
   // ***************************************************
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         EP_INT <= 1'b0;
      end else begin
         EP_INT <= |(ep_event & EP_INT_EN);
      end
   end

   // ***************************************************
   // register read port
   // ***************************************************
   usbefs_byte_t next_rdata;
   usbefs_byte_t status_byte;
   usbefs_cnt_t sel_count;

   assign sel_count = ep_count[ep_sel];

   always_comb begin
      status_byte = `USBEFS_RST_BYTE;
      status_byte[`USBEFS_BIT_STALL_CRC] = f_stall[ep_sel];
      status_byte[`USBEFS_BIT_SETUP] = f_setup[ep_sel];
      status_byte[`USBEFS_BIT_OUT_BANK0] = f_out[ep_sel];
      status_byte[`USBEFS_BIT_TX_COMPLETE] = f_txc[ep_sel];
   end

   always_comb begin
      next_rdata = `USBEFS_RST_BYTE;
      unique case (SFR_ADDR)
         `USBEFS_ADDR_EP_SELECT: begin
            next_rdata = {5'h00, ep_sel};
         end
         `USBEFS_ADDR_EP_STATUS: begin
            next_rdata = status_byte;
         end
         `USBEFS_ADDR_FIFO_DATA: begin
            next_rdata = rx_out.valid ? rx_out.data : `USBEFS_RST_BYTE;
         end
         `USBEFS_ADDR_COUNT_LOW: begin
            next_rdata = sel_count[7:0];
         end
         `USBEFS_ADDR_COUNT_HIGH: begin
            next_rdata = {5'h00, sel_count[10:8]};
         end
         `USBEFS_ADDR_EP_INT: begin
            next_rdata = {1'b0, ep_event};
         end
         default: begin
            next_rdata = `USBEFS_RST_BYTE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         SFR_RDATA <= `USBEFS_RST_BYTE;
      end else if (SFR_RD) begin
         SFR_RDATA <= next_rdata;
      end
   end
endmodule

// >>> sim/usbefs_top_monitor.sv
// concurrent checks on the ports of the endpoint status/fifo block
`timescale 1ns/1ps
`include "usbefs_map.svh"
module usbefs_top_monitor (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire usbefs_pkg::usbefs_byte_t SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire usbefs_pkg::usbefs_epmask_t EP_ISO,
   input wire usbefs_pkg::usbefs_epmask_t EP_CTRL,
   input wire usbefs_pkg::usbefs_epmask_t EP_INT_EN,
   input wire logic EP_INT,
   input wire usbefs_pkg::usbefs_ep_t LINK_EP,
   input wire logic LINK_SETUP,
   input wire logic LINK_RX_READY,
   input wire logic LINK_RX_END,
   input wire logic LINK_CRC_ERR,
   input wire logic LINK_OUT_NAK,
   input wire logic LINK_STALL_SENT,
   input wire logic LINK_IN_ACK,
   input wire logic LINK_TX_VALID
);
   import usbefs_pkg::*;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   a_stall_sets_int:
      assert property (LINK_STALL_SENT && !EP_ISO[LINK_EP] && EP_INT_EN[LINK_EP] |-> ##2 EP_INT)
      else $error("stall sent raised no interrupt");
   a_setup_sets_int:
      assert property (LINK_RX_END && LINK_SETUP && EP_CTRL[LINK_EP] && !LINK_CRC_ERR
         && EP_INT_EN[LINK_EP] |-> ##2 EP_INT) else $error("setup raised no interrupt");
   a_in_ack_int:
      assert property (LINK_IN_ACK && !EP_ISO[LINK_EP] && EP_INT_EN[LINK_EP] |-> ##2 EP_INT)
      else $error("in ack raised no interrupt");
   a_out_sets_int:
      assert property (LINK_RX_END && !LINK_SETUP && !LINK_OUT_NAK && !LINK_CRC_ERR
         && EP_INT_EN[LINK_EP] |-> ##2 EP_INT) else $error("out packet raised no interrupt");
   a_int_needs_enable:
      assert property (EP_INT_EN == 7'h00 |=> !EP_INT) else $error("interrupt while disabled");
   a_nak_not_iso:
      assert property (LINK_OUT_NAK |-> !EP_ISO[LINK_EP]) else $error("nak on iso endpoint");
   a_setup_not_nak:
      assert property (LINK_SETUP && EP_CTRL[LINK_EP] |-> !LINK_OUT_NAK)
      else $error("setup on control endpoint refused");
   a_pop_frees_room:
      assert property (SFR_RD && SFR_ADDR == `USBEFS_ADDR_FIFO_DATA && !LINK_RX_READY
         |=> LINK_RX_READY) else $error("read of full fifo freed no room");
   a_push_shows_tx:
      assert property (SFR_WR && SFR_ADDR == `USBEFS_ADDR_FIFO_DATA && !LINK_TX_VALID
         |-> ##[1:2] LINK_TX_VALID) else $error("pushed byte never offered");
endmodule
bind usbefs_top usbefs_top_monitor usbefs_top_monitor_inst (.REF_CLK(REF_CLK), .RST_N(RST_N),
   .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .EP_ISO(EP_ISO), .EP_CTRL(EP_CTRL),
   .EP_INT_EN(EP_INT_EN), .EP_INT(EP_INT), .LINK_EP(LINK_EP), .LINK_SETUP(LINK_SETUP),
   .LINK_RX_READY(LINK_RX_READY), .LINK_RX_END(LINK_RX_END), .LINK_CRC_ERR(LINK_CRC_ERR),
   .LINK_OUT_NAK(LINK_OUT_NAK), .LINK_STALL_SENT(LINK_STALL_SENT), .LINK_IN_ACK(LINK_IN_ACK),
   .LINK_TX_VALID(LINK_TX_VALID));

// >>> sim/usbefs_host_model.sv
// usb host side model driving the link events of the endpoint block
`timescale 1ns/1ps
module usbefs_host_model (
   input wire logic clk,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire usbefs_pkg::usbefs_byte_t tx_byte,
   output usbefs_pkg::usbefs_ep_t ep,
   output logic setup,
   output logic rx_start,
   output logic rx_valid,
   output usbefs_pkg::usbefs_byte_t rx_byte,
   output logic rx_end,
   output logic crc_err,
   output logic stall_sent,
   output logic in_ack,
   output logic tx_ready
);
   import usbefs_pkg::*;
   initial begin
      {ep, setup, rx_start, rx_valid, rx_end, crc_err, stall_sent, in_ack, tx_ready} = '0;
      rx_byte = 8'hA5;
   end
   task automatic point(input usbefs_ep_t e, input logic su);
      @(posedge clk);
      #1;
      ep = e;
      setup = su;
   endtask
   // only data bytes follow the start marker
   task automatic packet(input usbefs_byte_t d [$], input logic bad);
      @(posedge clk);
      #1;
      rx_start = 1'b1;
      @(posedge clk);
      #1;
      rx_start = 1'b0;
      foreach (d[i]) begin
         rx_valid = 1'b1;
         rx_byte = d[i];
         do @(negedge clk); while (!rx_ready);
         @(posedge clk);
         #1;
      end
      rx_valid = 1'b0;
      rx_byte = ~rx_byte;
      rx_end = 1'b1;
      crc_err = bad;
      @(posedge clk);
      #1;
      rx_end = 1'b0;
      crc_err = 1'b0;
   endtask
   task automatic strobe(input logic stall);
      @(posedge clk);
      #1;
      stall_sent = stall;
      in_ack = !stall;
      @(posedge clk);
      #1;
      stall_sent = 1'b0;
      in_ack = 1'b0;
   endtask
   task automatic take(output usbefs_byte_t b);
      @(posedge clk);
      #1;
      tx_ready = 1'b1;
      do @(negedge clk); while (!tx_valid);
      b = tx_byte;
      @(posedge clk);
      #1;
      tx_ready = 1'b0;
   endtask
endmodule

// >>> sim/tb.sv
// self-checking bench of the endpoint status/fifo block
`timescale 1ns/1ps
`include "usbefs_map.svh"
module tb;
   import usbefs_pkg::*;
   logic REF_CLK, RST_N, SFR_WR, SFR_RD, EP_INT, LINK_RX_READY, LINK_OUT_NAK, LINK_TX_VALID;
   logic LINK_SETUP, LINK_RX_START, LINK_RX_VALID, LINK_RX_END, LINK_CRC_ERR;
   logic LINK_STALL_SENT, LINK_IN_ACK, LINK_TX_READY;
   usbefs_byte_t SFR_ADDR, SFR_WDATA, SFR_RDATA, LINK_RX_BYTE, LINK_TX_BYTE, b;
   usbefs_epmask_t EP_ISO, EP_CTRL, EP_INT_EN;
   usbefs_ep_t LINK_EP;
   int err_total, samples_checked, cycles;
   logic [7:0] st [7];
   logic [10:0] cnt [7];
   logic [7:0] rxq [$];
   logic [7:0] q [$];
   usbefs_top usbefs_top_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR),
      .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
      .EP_ISO(EP_ISO), .EP_CTRL(EP_CTRL), .EP_INT_EN(EP_INT_EN), .EP_INT(EP_INT),
      .LINK_EP(LINK_EP), .LINK_SETUP(LINK_SETUP), .LINK_RX_START(LINK_RX_START),
      .LINK_RX_VALID(LINK_RX_VALID), .LINK_RX_BYTE(LINK_RX_BYTE), .LINK_RX_READY(LINK_RX_READY),
      .LINK_RX_END(LINK_RX_END), .LINK_CRC_ERR(LINK_CRC_ERR), .LINK_OUT_NAK(LINK_OUT_NAK),
      .LINK_STALL_SENT(LINK_STALL_SENT), .LINK_IN_ACK(LINK_IN_ACK),
      .LINK_TX_VALID(LINK_TX_VALID), .LINK_TX_BYTE(LINK_TX_BYTE), .LINK_TX_READY(LINK_TX_READY));
   usbefs_host_model host_inst (.clk(REF_CLK), .rx_ready(LINK_RX_READY),
      .tx_valid(LINK_TX_VALID), .tx_byte(LINK_TX_BYTE), .ep(LINK_EP), .setup(LINK_SETUP),
      .rx_start(LINK_RX_START), .rx_valid(LINK_RX_VALID), .rx_byte(LINK_RX_BYTE),
      .rx_end(LINK_RX_END), .crc_err(LINK_CRC_ERR), .stall_sent(LINK_STALL_SENT),
      .in_ack(LINK_IN_ACK), .tx_ready(LINK_TX_READY));
   initial begin
      REF_CLK = 1'b0;
      forever #25 REF_CLK = ~REF_CLK;
   end
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge REF_CLK);
      #1;
      SFR_ADDR = a;
      SFR_WDATA = d;
      SFR_WR = 1'b1;
      @(posedge REF_CLK);
      #1;
      SFR_WR = 1'b0;
   endtask
   task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge REF_CLK);
      #1;
      SFR_ADDR = a;
      SFR_RD = 1'b1;
      @(posedge REF_CLK);
      #1;
      SFR_RD = 1'b0;
      check(name, SFR_RDATA, exp);
   endtask
   function automatic logic exp_int();
      exp_int = 1'b0;
      for (int i = 0; i < 7; i++) exp_int |= (st[i] != 8'h00) && EP_INT_EN[i];
   endfunction
   function automatic logic [7:0] exp_ev();
      exp_ev = 8'h00;
      for (int i = 0; i < 7; i++) exp_ev[i] = (st[i] != 8'h00);
   endfunction
   task automatic regs(input int ep);
      wr(`USBEFS_ADDR_EP_SELECT, ep[7:0]);
      rdc("status", `USBEFS_ADDR_EP_STATUS, st[ep]);
      rdc("count_low", `USBEFS_ADDR_COUNT_LOW, cnt[ep][7:0]);
      rdc("count_high", `USBEFS_ADDR_COUNT_HIGH, {5'h00, cnt[ep][10:8]});
      check("interrupt", EP_INT, exp_int());
      rdc("events", `USBEFS_ADDR_EP_INT, exp_ev());
   endtask
   task automatic pkt(input int ep, input logic su, input logic crc, input int n);
      logic nak;
      q = {};
      for (int i = 0; i < n; i++) q.push_back(8'($urandom));
      host_inst.point(ep[2:0], su);
      nak = st[ep][1] && !EP_ISO[ep] && !(su && EP_CTRL[ep]);
      @(negedge REF_CLK);
      check("nak", LINK_OUT_NAK, nak);
      host_inst.packet(q, crc);
      if (!nak) rxq = {rxq, q};
      if (!nak) cnt[ep] = 11'(n);
      if (su && EP_CTRL[ep] && !crc) st[ep] = 8'h04;
      else if (!nak && !crc && !su) st[ep][1] = 1'b1;
      if (EP_ISO[ep]) st[ep][3] = crc;
      @(posedge REF_CLK);
      #1;
   endtask
   task automatic pulse(input int ep, input logic stall);
      host_inst.point(ep[2:0], 1'b0);
      host_inst.strobe(stall);
      if (!EP_ISO[ep]) st[ep][stall ? 3 : 0] = 1'b1;
      @(posedge REF_CLK);
      #1;
   endtask
   // write zero clears a flag, iso crc flag ignores writes
   task automatic clr(input int ep, input logic [7:0] d);
      wr(`USBEFS_ADDR_EP_SELECT, ep[7:0]);
      wr(`USBEFS_ADDR_EP_STATUS, d);
      st[ep] = st[ep] & (EP_ISO[ep] ? (d | 8'h08) : d);
   endtask
   task automatic drain(input int n);
      repeat (n) rdc("fifo", `USBEFS_ADDR_FIFO_DATA, rxq.pop_front());
   endtask
   initial begin
      {SFR_WR, SFR_RD, SFR_ADDR, SFR_WDATA, RST_N} = '0;
      {EP_ISO, EP_CTRL, EP_INT_EN} = {7'h04, 7'h01, 7'h00};
      {err_total, samples_checked, cycles} = '0;
      foreach (st[i]) {st[i], cnt[i]} = '0;
      void'($urandom(32'hF73C));
      repeat (8) @(posedge REF_CLK);
      #1;
      RST_N = 1'b1;
      repeat (3) @(posedge REF_CLK);
      regs(0);
      rdc("unmapped", 8'h80, 8'h00);
      $display("test reset done");
      EP_INT_EN = 7'h7F;
      pkt(1, 1'b0, 1'b0, 1 + $urandom_range(11));
      regs(1);
      pkt(1, 1'b0, 1'b0, 5);
      regs(1);
      drain(rxq.size());
      clr(1, 8'hFD);
      regs(1);
      $display("test bulk out done");
      pulse(0, 1'b1);
      pulse(0, 1'b0);
      regs(0);
      clr(0, 8'hFE);
      regs(0);
      pkt(0, 1'b0, 1'b0, 3);
      pkt(0, 1'b1, 1'b0, 8);
      regs(0);
      drain(rxq.size());
      clr(0, 8'hFB);
      regs(0);
      $display("test control done");
      pkt(2, 1'b0, 1'b0, 4);
      pkt(2, 1'b0, 1'b1, 4);
      clr(2, 8'hF5);
      rdc("iso_status", `USBEFS_ADDR_EP_STATUS, st[2]);
      pulse(2, 1'b1);
      pkt(2, 1'b0, 1'b0, 2);
      rdc("iso_status", `USBEFS_ADDR_EP_STATUS, st[2]);
      drain(rxq.size());
      $display("test iso done");
      EP_INT_EN = 7'($urandom);
      pkt(3, 1'b0, 1'b0, 16);
      check("rx_full", LINK_RX_READY, 1'b0);
      regs(3);
      drain(16);
      rdc("empty", `USBEFS_ADDR_FIFO_DATA, 8'h00);
      q = {};
      repeat (4) q.push_back(8'($urandom));
      foreach (q[i]) wr(`USBEFS_ADDR_FIFO_DATA, q[i]);
      foreach (q[i]) begin
         host_inst.take(b);
         check("tx", b, q[i]);
      end
      $display("test fifo done");
      final_report();
   end
endmodule
